// *** dv/mmd_decode_tb.sv ***
// Purpose: self-checking bench for the memory map decoder
// Assumes: registered answers one cycle after each request pulse
// Notes:   expectations come from map constants, never from outputs
`timescale 1ns/1ns
module mmd_decode_tb;
  // design inputs
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_prog_req = 1'b0, i_prog_is_table = 1'b0;
  logic i_prog_from_xdata = 1'b0, i_start = 1'b0, i_sfr_we = 1'b0, i_ptr_inc = 1'b0;
  logic i_xd_req = 1'b0, i_xd_we = 1'b0, i_xd_paged = 1'b0, i_id_req = 1'b0;
  logic i_id_indirect = 1'b0, i_id_use_reg = 1'b0, i_conv_req = 1'b0;
  logic [15:0] i_prog_addr = 16'h0000;
  logic [7:0]  i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_xd_ri = 8'h00, i_id_addr = 8'h00;
  logic [7:0]  i_xd_wdata = 8'ha5;
  logic [3:0]  i_vec_num = 4'h0, i_mux_divider = 4'h0;
  logic [2:0]  i_id_reg_num = 3'h0;
  logic [5:0]  i_conv_addr = 6'h00;
  // design outputs
  logic o_prog_rd, o_prog_refused, o_xd_stb, o_xd_we, o_conv_we, o_id_stb, o_id_is_sfr;
  logic o_id_bit_ok;
  logic [15:0] o_prog_addr, o_xd_addr, o_conv_addr, o_primary_pointer, o_secondary_pointer;
  logic [7:0]  o_xd_wdata, o_id_addr, o_pointer_select, o_page_high_byte;
  logic [7:0]  o_program_status_word, conv_cnt;
  logic [1:0]  o_xd_target;
  int n_mismatch = 0, n_checks = 0, cyc = 0;

  mmd_decode u_mmd_decode (.i_mclk, .i_rst_n, .i_prog_req, .i_prog_is_table,
    .i_prog_from_xdata, .i_prog_addr, .i_start, .i_vec_num, .i_sfr_we, .i_sfr_addr,
    .i_sfr_wdata, .i_ptr_inc, .i_xd_req, .i_xd_we, .i_xd_paged, .i_xd_ri, .i_xd_wdata,
    .i_id_req, .i_id_indirect, .i_id_addr, .i_id_reg_num, .i_id_use_reg, .i_mux_divider,
    .i_conv_req, .i_conv_addr, .o_prog_rd, .o_prog_addr, .o_prog_refused, .o_xd_stb,
    .o_xd_we, .o_xd_addr, .o_xd_wdata, .o_xd_target, .o_conv_we, .o_conv_addr, .o_id_stb,
    .o_id_addr, .o_id_is_sfr, .o_id_bit_ok, .o_pointer_select, .o_page_high_byte,
    .o_program_status_word, .o_primary_pointer, .o_secondary_pointer);
  mmd_mem_model u_mmd_mem_model (.i_mclk, .i_stb(o_xd_stb), .i_we(o_xd_we),
    .i_addr(o_xd_addr), .i_wdata(o_xd_wdata), .i_target(o_xd_target),
    .i_conv_we(o_conv_we), .i_conv_addr(o_conv_addr), .o_conv_cnt(conv_cnt));

  // clock
  always #5 i_mclk = ~i_mclk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // hang guard, the sequence needs about 120 cycles
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  // wide enough for the flag plus address concatenations used below
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // pulses drop at the sampling edge, outputs are read 1 ns later
  task automatic tick();
    @(posedge i_mclk);
    i_prog_req <= 1'b0;
    i_start <= 1'b0;
    i_sfr_we <= 1'b0;
    i_ptr_inc <= 1'b0;
    i_xd_req <= 1'b0;
    i_id_req <= 1'b0;
    i_conv_req <= 1'b0;
    #1;
  endtask

  task automatic prog(input logic st, input logic xd, input logic [15:0] a,
                      input logic [3:0] v);
    @(posedge i_mclk);
    i_prog_req <= ~st;
    i_start <= st;
    i_prog_from_xdata <= xd;
    i_prog_addr <= a;
    i_vec_num <= v;
    tick();
  endtask

  task automatic sfr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_sfr_we <= 1'b1;
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    tick();
  endtask

  task automatic xd(input logic pg, input logic [7:0] ri);
    @(posedge i_mclk);
    i_xd_req <= 1'b1;
    i_xd_we <= 1'b1;
    i_xd_paged <= pg;
    i_xd_ri <= ri;
    tick();
  endtask

  task automatic idr(input logic ind, input logic use_reg, input logic [7:0] a);
    @(posedge i_mclk);
    i_id_req <= 1'b1;
    i_id_indirect <= ind;
    i_id_use_reg <= use_reg;
    i_id_reg_num <= 3'h5;
    i_id_addr <= a;
    tick();
  endtask

  task automatic conv(input logic [3:0] dv);
    @(posedge i_mclk);
    i_mux_divider <= dv;
    i_conv_req <= 1'b1;
    i_conv_addr <= 6'h3f;
    tick();
  endtask

  // expected external map, address and target per boundary
  logic [15:0] xa [6] = '{16'h13ff, 16'h1400, 16'h2000, 16'h27ff, 16'h287f, 16'h2880};
  logic [1:0]  xt [6] = '{2'h1, 2'h0, 2'h2, 2'h2, 2'h3, 2'h0};

  initial
  begin
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    #1;
    chk(o_page_high_byte, 16'h0000);
    prog(1'b0, 1'b0, 16'h1234, 4'h0);
    chk({o_prog_rd, o_prog_addr}, 17'h10000);
    prog(1'b0, 1'b0, 16'hffff, 4'h0);
    chk({o_prog_rd, o_prog_addr}, 17'h1ffff);
    prog(1'b0, 1'b1, 16'h0100, 4'h0);
    chk({o_prog_rd, o_prog_refused}, 2'b01);
    for (int n = 0; n < 16; n++)
    begin
      prog(1'b1, 1'b0, 16'h0000, 4'(n));
      chk(o_prog_addr, mmd_pkg::VEC_BASE + 16'(n * 8));
    end
    for (int k = 0; k < 6; k++)
    begin
      sfr(mmd_pkg::SFR_PTR_HI0, xa[k][15:8]);
      sfr(mmd_pkg::SFR_PTR_LO0, xa[k][7:0]);
      xd(1'b0, 8'h00);
      chk({o_xd_stb, o_xd_target, o_xd_addr}, {xt[k] != 2'h0, xt[k], xa[k]});
    end
    chk(16'(u_mmd_mem_model.mem[16'h13ff]), 16'h00a5);
    sfr(mmd_pkg::SFR_PTR_SEL, 8'h01);
    chk(o_pointer_select, 16'h0001);
    sfr(mmd_pkg::SFR_PTR_HI1, 8'h12);
    sfr(mmd_pkg::SFR_PTR_LO1, 8'h34);
    chk(o_primary_pointer, 16'h2880);
    xd(1'b0, 8'h00);
    chk(o_xd_addr, 16'h1234);
    @(posedge i_mclk);
    i_ptr_inc <= 1'b1;
    tick();
    chk({o_secondary_pointer, o_primary_pointer}, 32'h12352880);
    sfr(mmd_pkg::SFR_PTR_SEL, 8'h00);
    xd(1'b0, 8'h00);
    chk({o_xd_stb, o_xd_addr}, 17'h02880);
    sfr(mmd_pkg::SFR_PAGE_HIGH, 8'h21);
    chk({o_page_high_byte, o_program_status_word}, 16'h2100);
    xd(1'b1, 8'h05);
    chk({o_xd_stb, o_xd_target, o_xd_addr}, {1'b1, 2'h2, 16'h2105});
    sfr(mmd_pkg::SFR_STATUS_WORD, 8'h10);
    chk(o_program_status_word, 16'h0010);
    idr(1'b0, 1'b1, 8'h00);
    chk(o_id_addr, 16'h0015);
    idr(1'b0, 1'b0, 8'h90);
    chk({o_id_stb, o_id_is_sfr}, 2'b11);
    idr(1'b1, 1'b0, 8'hff);
    chk({o_id_is_sfr, o_id_addr}, 9'h0ff);
    idr(1'b1, 1'b0, 8'h2f);
    chk({o_id_is_sfr, o_id_bit_ok}, 2'b01);
    idr(1'b0, 1'b0, 8'h30);
    chk({o_id_is_sfr, o_id_bit_ok}, 2'b00);
    conv(4'h3);
    chk({o_conv_we, o_conv_addr}, 17'h1003f);
    conv(mmd_pkg::DIV_OFF);
    chk({o_conv_we, conv_cnt}, 9'h001);
    conv(4'h2);
    chk({o_conv_we, conv_cnt}, 16'h0101);
    // the model counts the strobe one edge after the block raises it
    tick();
    chk(conv_cnt, 16'h0002);
    final_report();
  end
endmodule

// *** dv/mmd_mem_model.sv ***
// Purpose: far-side memory model for shared, config and battery ram
// Assumes: strobes are single-cycle and already decoded by the block
// Notes:   only writes are kept; the core never reads back through here
`timescale 1ns/1ns
module mmd_mem_model (
  // clock
  input  wire logic        i_mclk,
  // external data strobe
  input  wire logic        i_stb,
  input  wire logic        i_we,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic [1:0]  i_target,
  // converter strobe
  input  wire logic        i_conv_we,
  input  wire logic [15:0] i_conv_addr,
  // converter write count
  output logic [7:0]       o_conv_cnt
);
  // mapped span only, gaps are never written since target is none there
  logic [7:0] mem [0:16'h287f];
  initial o_conv_cnt = 8'h00;
  // data writes land only where the block named a target; converter writes always land
  always @(posedge i_mclk)
  begin
    if (i_stb && i_we && i_target != 2'h0)
      mem[i_addr] <= i_wdata;
    if (i_conv_we)
    begin
      mem[i_conv_addr] <= 8'h5a;
      o_conv_cnt <= o_conv_cnt + 8'h01;
    end
  end
endmodule

// *** logic/mmd_decode.sv ***
// Purpose: memory map decode, pointer and page logic for the processor
// Assumes: one request at a time from the core, same clock, one-cycle strobes
// Notes:   all outputs registered, so answers follow requests by one cycle
`timescale 1ns/1ns
module mmd_decode #(
  parameter int VEC_COUNT = 16
)(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // program space request
  input  wire logic        i_prog_req,
  input  wire logic        i_prog_is_table,
  input  wire logic        i_prog_from_xdata,
  input  wire logic [15:0] i_prog_addr,
  input  wire logic        i_start,
  input  wire logic [3:0]  i_vec_num,
  // special function register writes
  input  wire logic        i_sfr_we,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic [7:0]  i_sfr_wdata,
  // pointer increment from the core
  input  wire logic        i_ptr_inc,
  // external data request
  input  wire logic        i_xd_req,
  input  wire logic        i_xd_we,
  input  wire logic        i_xd_paged,
  input  wire logic [7:0]  i_xd_ri,
  input  wire logic [7:0]  i_xd_wdata,
  // internal data request
  input  wire logic        i_id_req,
  input  wire logic        i_id_indirect,
  input  wire logic [7:0]  i_id_addr,
  input  wire logic [2:0]  i_id_reg_num,
  input  wire logic        i_id_use_reg,
  // converter side
  input  wire logic [3:0]  i_mux_divider,
  input  wire logic        i_conv_req,
  input  wire logic [5:0]  i_conv_addr,
  // program space answer
  output logic             o_prog_rd,
  output logic [15:0]      o_prog_addr,
  output logic             o_prog_refused,
  // external data answer
  output logic             o_xd_stb,
  output logic             o_xd_we,
  output logic [15:0]      o_xd_addr,
  output logic [7:0]       o_xd_wdata,
  output logic [1:0]       o_xd_target,
  // converter write strobe
  output logic             o_conv_we,
  output logic [15:0]      o_conv_addr,
  // internal data answer
  output logic             o_id_stb,
  output logic [7:0]       o_id_addr,
  output logic             o_id_is_sfr,
  output logic             o_id_bit_ok,
  // register state
  output logic [7:0]       o_pointer_select,
  output logic [7:0]       o_page_high_byte,
  output logic [7:0]       o_program_status_word,
  output logic [15:0]      o_primary_pointer,
  output logic [15:0]      o_secondary_pointer
);

  initial
  begin
    if (VEC_COUNT < 1 || VEC_COUNT > 16)
      $error("VEC_COUNT out of range");
  end

  logic [7:0]  pointer_select_r;
  logic [7:0]  page_high_byte_r;
  logic [7:0]  program_status_word_r;
  logic [15:0] primary_pointer_r;
  logic [15:0] secondary_pointer_r;
  logic [15:0] sel_ptr;
  logic [15:0] xd_addr_nxt;
  logic [7:0]  id_addr_nxt;
  logic        pending_start_r;

  // classify an external address into its target
  function automatic logic [1:0] xd_target(input logic [15:0] a);
    if (a <= mmd_pkg::SHARED_HI)
      xd_target = 2'(mmd_pkg::MMD_TGT_SHARED);
    else if (a >= mmd_pkg::CFG_LO && a <= mmd_pkg::CFG_HI)
      xd_target = 2'(mmd_pkg::MMD_TGT_CFG);
    else if (a >= mmd_pkg::BAT_LO && a <= mmd_pkg::BAT_HI)
      xd_target = 2'(mmd_pkg::MMD_TGT_BAT);
    else
      xd_target = 2'(mmd_pkg::MMD_TGT_NONE);
  endfunction

  // currently selected pointer
  assign sel_ptr = pointer_select_r[mmd_pkg::PTR_SEL_BIT] ? secondary_pointer_r
                                                           : primary_pointer_r;

  // external address: paged from register plus page byte, else pointer
  assign xd_addr_nxt = i_xd_paged ? {page_high_byte_r, i_xd_ri}
                                  : sel_ptr;

  // working register slot from active bank, else supplied address
  assign id_addr_nxt = i_id_use_reg
    ? {3'h0, program_status_word_r[mmd_pkg::BANK_LO_BIT +: 2], i_id_reg_num}
    : i_id_addr;

  // special function registers; select writes touch no pointer
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pointer_select_r      <= mmd_pkg::RST_BYTE;
      page_high_byte_r      <= mmd_pkg::RST_BYTE;
      program_status_word_r <= mmd_pkg::RST_BYTE;
    end
    else if (i_sfr_we)
    begin
      if (i_sfr_addr == mmd_pkg::SFR_PTR_SEL)
        pointer_select_r <= i_sfr_wdata;
      if (i_sfr_addr == mmd_pkg::SFR_PAGE_HIGH)
        page_high_byte_r <= i_sfr_wdata;
      if (i_sfr_addr == mmd_pkg::SFR_STATUS_WORD)
        program_status_word_r <= i_sfr_wdata;
    end
  end

  // pointer bytes; increments act on the selected pointer only
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      primary_pointer_r   <= {mmd_pkg::RST_BYTE, mmd_pkg::RST_BYTE};
      secondary_pointer_r <= {mmd_pkg::RST_BYTE, mmd_pkg::RST_BYTE};
    end
    else if (i_sfr_we)
    begin
      if (i_sfr_addr == mmd_pkg::SFR_PTR_LO0)
        primary_pointer_r[7:0] <= i_sfr_wdata;
      if (i_sfr_addr == mmd_pkg::SFR_PTR_HI0)
        primary_pointer_r[15:8] <= i_sfr_wdata;
      if (i_sfr_addr == mmd_pkg::SFR_PTR_LO1)
        secondary_pointer_r[7:0] <= i_sfr_wdata;
      if (i_sfr_addr == mmd_pkg::SFR_PTR_HI1)
        secondary_pointer_r[15:8] <= i_sfr_wdata;
    end
    else if (i_ptr_inc)
    begin
      if (pointer_select_r[mmd_pkg::PTR_SEL_BIT])
        secondary_pointer_r <= secondary_pointer_r + 16'h0001;
      else
        primary_pointer_r <= primary_pointer_r + 16'h0001;
    end
  end

  // first program request after reset release forced to zero, fetch or table read alike; a start or refused request first clears this
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pending_start_r <= 1'b1;
    else if (i_prog_req || i_start)
      pending_start_r <= 1'b0;
  end

  // program reads: fetches and table reads only, vectors computed here
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_prog_rd      <= 1'b0;
      o_prog_addr    <= mmd_pkg::RST_FETCH_ADDR;
      o_prog_refused <= 1'b0;
    end
    else
    begin
      o_prog_rd      <= 1'b0;
      o_prog_refused <= 1'b0;
      if (i_prog_req && i_prog_from_xdata)
        o_prog_refused <= 1'b1;
      else if (i_start && 32'(i_vec_num) < VEC_COUNT)
      begin
        o_prog_rd   <= 1'b1;
        o_prog_addr <= mmd_pkg::VEC_BASE + (16'(i_vec_num) << mmd_pkg::VEC_SHIFT);
      end
      else if (i_prog_req)
      begin
        o_prog_rd   <= 1'b1;
        o_prog_addr <= pending_start_r ? mmd_pkg::RST_FETCH_ADDR
                                       : i_prog_addr;
      end
    end
  end

  // external data strobe; unmapped targets get no strobe effect downstream
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_xd_stb    <= 1'b0;
      o_xd_we     <= 1'b0;
      o_xd_addr   <= 16'h0000;
      o_xd_wdata  <= 8'h00;
      o_xd_target <= 2'(mmd_pkg::MMD_TGT_NONE);
    end
    else
    begin
      o_xd_stb    <= i_xd_req && (xd_target(xd_addr_nxt) != 2'(mmd_pkg::MMD_TGT_NONE));
      o_xd_we     <= i_xd_req && i_xd_we;
      o_xd_addr   <= xd_addr_nxt;
      o_xd_wdata  <= i_xd_wdata;
      o_xd_target <= xd_target(xd_addr_nxt);
    end
  end

  // converter writes into the low shared bytes while divider nonzero
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_conv_we   <= 1'b0;
      o_conv_addr <= mmd_pkg::SHARED_LO;
    end
    else
    begin
      o_conv_we   <= i_conv_req && (i_mux_divider != mmd_pkg::DIV_OFF);
      o_conv_addr <= mmd_pkg::SHARED_LO + {10'h000, i_conv_addr};
    end
  end

  // internal data: direct upper half goes to registers, indirect to RAM
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_id_stb    <= 1'b0;
      o_id_addr   <= 8'h00;
      o_id_is_sfr <= 1'b0;
      o_id_bit_ok <= 1'b0;
    end
    else
    begin
      o_id_stb    <= i_id_req;
      o_id_addr   <= id_addr_nxt;
      o_id_is_sfr <= !i_id_indirect && id_addr_nxt >= mmd_pkg::IRAM_UPPER;
      o_id_bit_ok <= id_addr_nxt >= mmd_pkg::BIT_AREA_LO
                  && id_addr_nxt <= mmd_pkg::BIT_AREA_HI;
    end
  end

  assign o_pointer_select      = pointer_select_r;
  assign o_page_high_byte      = page_high_byte_r;
  assign o_program_status_word = program_status_word_r;
  assign o_primary_pointer     = primary_pointer_r;
  assign o_secondary_pointer   = secondary_pointer_r;

  // assertions
  a_conv_gate_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $past(i_mux_divider) == 4'h0 |-> !o_conv_we)
    else $error("converter wrote with divider off");
  a_conv_span: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_conv_we |-> o_conv_addr < mmd_pkg::CONV_SPAN)
    else $error("converter address outside low span");
  a_page_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_xd_req && i_xd_paged |=> o_xd_addr == {$past(page_high_byte_r), $past(i_xd_ri)})
    else $error("paged address wrong");
  a_ptr_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_xd_req && !i_xd_paged && pointer_select_r[0] |=> o_xd_addr == $past(secondary_pointer_r))
    else $error("pointer address wrong");
  a_sel_keeps: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_sfr_we && i_sfr_addr == mmd_pkg::SFR_PTR_SEL |=> $stable(primary_pointer_r)
      && $stable(secondary_pointer_r))
    else $error("select write changed a pointer");
  a_unmapped_none: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_xd_target == 2'(mmd_pkg::MMD_TGT_NONE) |-> !o_xd_stb)
    else $error("unmapped access strobed");
  a_sfr_direct: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_id_req && i_id_indirect |=> !o_id_is_sfr)
    else $error("indirect access reached registers");
  a_xdata_no_prog: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_prog_req && i_prog_from_xdata |=> o_prog_refused && !o_prog_rd)
    else $error("program read for external data");
  a_vector_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_start && !(i_prog_req && i_prog_from_xdata) && i_vec_num == 4'h1
      |=> o_prog_addr == 16'h000b)
    else $error("vector address wrong");
  a_bank_slot: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_id_req && i_id_use_reg |=> o_id_addr < 8'h20)
    else $error("register slot outside banks");

endmodule

// *** pkg/mmd_pkg.sv ***
// Purpose: constants for the processor memory map decoder
// Assumes: processor core presents decoded access requests on one clock
// Notes:   Overview of operation
package mmd_pkg;
  // register offsets in special function space
  localparam logic [7:0]  SFR_PTR_LO0     = 8'h82;
  localparam logic [7:0]  SFR_PTR_HI0     = 8'h83;
  localparam logic [7:0]  SFR_PTR_LO1     = 8'h84;
  localparam logic [7:0]  SFR_PTR_HI1     = 8'h85;
  localparam logic [7:0]  SFR_PTR_SEL     = 8'h92;
  localparam logic [7:0]  SFR_PAGE_HIGH   = 8'hbf;
  localparam logic [7:0]  SFR_STATUS_WORD = 8'hd0;
  // reset values
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [15:0] RST_FETCH_ADDR  = 16'h0000;
  // field positions
  localparam int          PTR_SEL_BIT     = 0;
  localparam int          BANK_LO_BIT     = 3;
  // program vectors
  localparam logic [15:0] VEC_BASE        = 16'h0003;
  localparam int          VEC_SHIFT       = 3;
  // external data ranges
  localparam logic [15:0] SHARED_LO       = 16'h0000;
  localparam logic [15:0] SHARED_HI       = 16'h13ff;
  localparam logic [15:0] CFG_LO          = 16'h2000;
  localparam logic [15:0] CFG_HI          = 16'h27ff;
  localparam logic [15:0] BAT_LO          = 16'h2800;
  localparam logic [15:0] BAT_HI          = 16'h287f;
  localparam logic [15:0] CONV_SPAN       = 16'h0040;
  // internal space, and converter divider off value
  localparam logic [7:0]  IRAM_UPPER      = 8'h80;
  localparam logic [7:0]  BIT_AREA_LO     = 8'h20;
  localparam logic [7:0]  BIT_AREA_HI     = 8'h2f;
  localparam logic [3:0]  DIV_OFF         = 4'h0;
  // external target select
  typedef enum logic [1:0] {MMD_TGT_NONE, MMD_TGT_SHARED, MMD_TGT_CFG, MMD_TGT_BAT} mmd_tgt_e;
endpackage
